//--- pkg/lcs_defs.vh
// Purpose: constants for the display clock and standby control block
// Assumes: 40 MHz system clock, oscillator input sampled as a level
// Notes:   all widths fixed
`ifndef LCS_DEFS_VH
`define LCS_DEFS_VH
`define LCS_DIV_BY2          2'h0
`define LCS_DIV_BY4          2'h1
`define LCS_DIV_BY8          2'h2
`define LCS_DIV_BY16         2'h3
`define LCS_DIV_RESET        2'h3
`define LCS_TERM_BY2         4'h1
`define LCS_TERM_BY4         4'h3
`define LCS_TERM_BY8         4'h7
`define LCS_TERM_BY16        4'hf
`define LCS_CMD_SETDIV_MASK  8'hf0
`define LCS_CMD_SETDIV_CODE  8'ha0
`define LCS_CMD_STOP         8'h84
`define LCS_CMD_STOP_MASK    8'hef
`define LCS_CONTRAST_MASK    8'hee
`define LCS_CMD_CONTRAST     8'h82
`define LCS_ICON_MASK        5'h1f
`define LCS_LINE_TICKS       4'h4
`define LCS_BUSY_LINES       2'h2
`define LCS_CNT_ZERO         3'h0
`define LCS_CNT_ONE          3'h1
`define LCS_OFFSET_ZERO      4'h0
`endif

//--- core/lcs_clock_divider.v
// Purpose: divide the oscillator input by 2, 4, 8 or 16
// Assumes: oscillator level already synchronised to clk
// Notes:   emits a one-cycle tick per divided internal clock period
`timescale 1ns/100ps
`include "lcs_defs.vh"
module lcs_clock_divider (
    input  wire       clk,
    input  wire       reset,
    input  wire       oscLevel,
    input  wire       run,
    input  wire [1:0] divSel,
    output reg        internalTick
);
    reg       oscPrev;
    reg [3:0] edgeCount;
    reg [3:0] limit;
    // terminal count for the selected ratio (edges of the input)
    always @* begin
        case (divSel)
            `LCS_DIV_BY2:  limit = `LCS_TERM_BY2;
            `LCS_DIV_BY4:  limit = `LCS_TERM_BY4;
            `LCS_DIV_BY8:  limit = `LCS_TERM_BY8;
            default:       limit = `LCS_TERM_BY16;
        endcase
    end
    // count rising input edges; halted in standby
    always @(posedge clk) begin
        if (reset) begin
            oscPrev      <= 1'b0;
            edgeCount    <= 4'h0;
            internalTick <= 1'b0;
        end else begin
            oscPrev      <= oscLevel;
            internalTick <= 1'b0;
            if (run && oscLevel && !oscPrev) begin
                if (edgeCount >= limit) begin
                    edgeCount    <= 4'h0;
                    internalTick <= 1'b1;
                end else begin
                    edgeCount <= edgeCount + 4'h1;
                end
            end
        end
    end
endmodule

//--- core/lcs_clock_standby_control.v
// Purpose: internal clock division, frame pacing, busy timing, standby
// Assumes: received bytes arrive as one-cycle strobes on clk
// Notes:   oscillator and straps come from pins and are synchronised
// Behaviour
// - with source select low, divide oscillator input by field ratio
// - divider field unknown until programmed; any ratio 1/2..1/16 allowed
// - frame rate follows internal clock, 32.768 kHz as reference
// - each command completes within two common-line periods
// - standby entered by reset pin or stop command
// - reset pin sets contrast to strap minimum; stop keeps contrast
// - other settings kept through standby
// - byte with bit zero set wakes device and is processed
// - icon data top three bits ignored
// - codes 00..11 select divide by 2, 4, 8, 16
// - stop halts oscillator stage and drives outputs to supply

`timescale 1ns/100ps
`include "lcs_defs.vh"
module lcs_clock_standby_control (
    input  wire       clk,
    input  wire       reset,
    input  wire       oscillatorInput,
    input  wire       clockSourceSelectPin,
    input  wire       contrastOffsetStrapLow,
    input  wire       contrastOffsetStrapHigh,
    input  wire       byteValid,
    input  wire [7:0] byteData,
    input  wire       byteIsCommand,
    input  wire       byteIsIcon,
    output reg        standby,
    output reg        busy,
    output reg        frameTick,
    output reg        internalClockTick,
    output reg  [1:0] dividerSelect,
    output reg  [2:0] contrastCount,
    output reg  [3:0] contrastLevel,
    output reg        outputsAtSupply,
    output reg        iconValid,
    output reg  [4:0] iconData
);

    reg        oscMeta;
    reg        oscSync;
    reg        srcMeta;
    reg        srcSync;
    reg  [1:0] strapMeta;
    reg  [1:0] strapSync;
    reg  [3:0] lineCount;
    reg  [1:0] busyLines;

    wire       divTick;
    wire       extTick;
    wire       tick;
    wire       isSetDiv;
    wire       isStop;
    wire       isContrast;
    wire       wake;
    wire       accept;
    wire       dividerRun;
    wire       lineLast;

    // two-stage synchronisers for pin inputs
    always @(posedge clk) begin
        if (reset) begin
            oscMeta   <= 1'b0;
            oscSync   <= 1'b0;
            srcMeta   <= 1'b0;
            srcSync   <= 1'b0;
            strapMeta <= 2'h0;
            strapSync <= 2'h0;
        end else begin
            oscMeta   <= oscillatorInput;
            oscSync   <= oscMeta;
            srcMeta   <= clockSourceSelectPin;
            srcSync   <= srcMeta;
            strapMeta <= {contrastOffsetStrapHigh, contrastOffsetStrapLow};
            strapSync <= strapMeta;
        end
    end

    assign dividerRun = !standby;

    lcs_clock_divider divider (
        .clk          (clk),
        .reset        (reset),
        .oscLevel     (oscSync),
        .run          (dividerRun),
        .divSel       (dividerSelect),
        .internalTick (divTick)
    );

    // direct source edge when select high
    reg oscPrevDirect;
    always @(posedge clk) begin
        if (reset)
            oscPrevDirect <= 1'b0;
        else
            oscPrevDirect <= oscSync;
    end
    assign extTick = oscSync && !oscPrevDirect && dividerRun;

    assign tick = srcSync ? extTick : divTick;

    // command decode
    assign isSetDiv   = byteIsCommand &&
        ((byteData & `LCS_CMD_SETDIV_MASK) == `LCS_CMD_SETDIV_CODE);
    assign isStop     = byteIsCommand &&
        ((byteData & `LCS_CMD_STOP_MASK) == `LCS_CMD_STOP);
    assign isContrast = byteIsCommand &&
        ((byteData & `LCS_CONTRAST_MASK) == `LCS_CMD_CONTRAST);

    // wake on bit zero regardless of command/data
    assign wake = byteValid && byteData[0];

    // byte taken when awake, or when it is the waking byte
    assign accept = byteValid && (!standby || wake);

    // divider field and standby state
    always @(posedge clk) begin
        if (reset) begin
            // power-on ratio is an arbitrary legal value
            dividerSelect <= `LCS_DIV_RESET;
            standby       <= 1'b1;
        end else begin
            if (accept && isSetDiv)
                dividerSelect <= byteData[1:0];
            // stop enters standby, wake leaves it
            if (accept && isStop)
                standby <= 1'b1;
            else if (wake)
                standby <= 1'b0;
        end
    end

    // contrast: strap minimum on reset, kept across stop
    always @(posedge clk) begin
        if (reset) begin
            contrastCount <= `LCS_CNT_ZERO;
        end else if (accept && isContrast) begin
            if (byteData[0])
                contrastCount <= contrastCount + `LCS_CNT_ONE;
            else
                contrastCount <= contrastCount - `LCS_CNT_ONE;
        end
    end

    always @(posedge clk) begin
        if (reset)
            contrastLevel <= `LCS_OFFSET_ZERO;
        else
            contrastLevel <= {1'b0, contrastCount} + {2'h0, strapSync};
    end

    // last internal tick of a common-line period
    assign lineLast = (lineCount == `LCS_LINE_TICKS - 4'h1);

    // frame pacing from internal clock ticks
    always @(posedge clk) begin
        if (reset) begin
            lineCount <= 4'h0;
            frameTick <= 1'b0;
        end else begin
            frameTick <= 1'b0;
            if (tick) begin
                if (lineLast) begin
                    lineCount <= 4'h0;
                    frameTick <= 1'b1;
                end else begin
                    lineCount <= lineCount + 4'h1;
                end
            end
        end
    end

    // busy up to two common-line periods after each accepted byte; standby clears it
    always @(posedge clk) begin
        if (reset) begin
            busy      <= 1'b0;
            busyLines <= 2'h0;
        end else if (accept) begin
            busy      <= 1'b1;
            busyLines <= `LCS_BUSY_LINES;
        end else if (standby) begin // stop ends at once, no ticks
            busy      <= 1'b0;
            busyLines <= 2'h0;
        end else if (busy && frameTick) begin
            if (busyLines == 2'h1)
                busy <= 1'b0;
            busyLines <= busyLines - 2'h1;
        end
    end

    // outputs held at supply and tick exported
    always @(posedge clk) begin
        if (reset) begin
            outputsAtSupply   <= 1'b1;
            internalClockTick <= 1'b0;
        end else begin
            outputsAtSupply   <= standby && !wake;
            internalClockTick <= tick;
        end
    end

    // icon row data, only for bytes that are taken
    always @(posedge clk) begin
        if (reset) begin
            iconValid <= 1'b0;
            iconData  <= 5'h00;
        end else begin
            iconValid <= accept && byteIsIcon && !byteIsCommand;
            if (accept && byteIsIcon && !byteIsCommand)
                iconData <= byteData[4:0] & `LCS_ICON_MASK;
        end
    end

endmodule

//--- tb/lcs_clock_standby_control_properties.sv
// Purpose: port timing checks for the clock and standby block
// Assumes: one clk domain, synchronous reset
// Notes:   bound below
`timescale 1ns/100ps
module lcs_checker (
    input wire       clk,
    input wire       reset,
    input wire       byteValid,
    input wire [7:0] byteData,
    input wire       byteIsCommand,
    input wire       byteIsIcon,
    input wire       standby,
    input wire       busy,
    input wire       frameTick,
    input wire [1:0] dividerSelect,
    input wire [2:0] contrastCount,
    input wire       outputsAtSupply,
    input wire       iconValid,
    input wire [4:0] iconData
);
    // byte accepted when awake or waking
    wire tk = byteValid && (!standby || byteData[0]);
    wire cmd = tk && byteIsCommand;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    AST_DIV: assert property (cmd && (byteData & 8'hf0) == 8'ha0 |=>
        dividerSelect == $past(byteData[1:0])) else $error("divider code");
    AST_STOP: assert property (cmd && (byteData & 8'hef)==8'h84 |=>
        standby && $stable(contrastCount) && $stable(dividerSelect))
        else $error("stop entry");
    AST_SUPPLY: assert property ($rose(standby) |=> outputsAtSupply)
        else $error("outputs not at supply");
    AST_WAKE: assert property (standby && byteValid && byteData[0] |=>
        !standby) else $error("no wake");
    AST_REFUSE: assert property (standby && byteValid && !byteData[0] |=>
        standby && $stable(dividerSelect)) else $error("byte not refused");
    AST_ICON: assert property (tk && !byteIsCommand && byteIsIcon |=>
        iconValid && iconData == $past(byteData[4:0])) else $error("icon");
    AST_BUSY: assert property ($rose(busy) |-> ##[1:900] !busy)
        else $error("busy too long");
    AST_RST: assert property ($past(reset) |->
        standby && contrastCount == 3'h0) else $error("reset state");
    AST_FRAME: assert property (frameTick |=> !frameTick [*8])
        else $error("frame too fast");
endmodule
bind lcs_clock_standby_control lcs_checker chk_u (.clk(clk), .reset(reset),
    .byteValid(byteValid), .byteData(byteData), .byteIsCommand(byteIsCommand),
    .byteIsIcon(byteIsIcon), .standby(standby), .busy(busy),
    .frameTick(frameTick), .dividerSelect(dividerSelect),
    .contrastCount(contrastCount), .outputsAtSupply(outputsAtSupply),
    .iconValid(iconValid), .iconData(iconData));

//--- tb/lcs_host_model.sv
// Purpose: host byte source
// Assumes: bytes already framed by the serial receiver
// Notes:   idle lines show the inverse of the last byte
`timescale 1ns/100ps
module lcs_host_model (
    input  wire       clk,
    output reg        byteValid = 1'b0,
    output reg  [7:0] byteData = 8'h00,
    output reg        byteIsCommand = 1'b0,
    output reg        byteIsIcon = 1'b0
);
    // one-cycle byte strobe, caller waits on busy
    task put(input c, input i, input [7:0] d);
        begin
            @(posedge clk) #1;
            byteValid = 1'b1;
            byteIsCommand = c;
            byteIsIcon = i;
            byteData = i ? {3'($urandom), d[4:0]} : d;
            @(posedge clk) #1;
            byteValid = 1'b0;
            byteData = ~byteData;
            byteIsCommand = ~c;
            byteIsIcon = ~i;
        end
    endtask
endmodule

//--- tb/tb_lcs_clock_standby_control.sv
// Purpose: self-checking bench for the clock and standby block
// Assumes: oscillator input period of 4 clk cycles
// Notes:   reference state kept in integers
`timescale 1ns/100ps
module tb_lcs_clock_standby_control;
    reg        clk = 1'b0, reset = 1'b1, osc = 1'b0, sLo = 1'b0, sHi = 1'b0;
    reg        src = 1'b0;
    wire       bv, bc, bi, sb, bz, ft, it, oas, iv;
    wire [7:0] bd;
    wire [1:0] ds;
    wire [2:0] cc;
    wire [3:0] cl;
    wire [4:0] id;
    integer    num_errors = 0, n_tests = 0, eS, eD, eC, k, n;
    lcs_host_model host_u (.clk(clk), .byteValid(bv), .byteData(bd),
        .byteIsCommand(bc), .byteIsIcon(bi));
    lcs_clock_standby_control dut_u (.clk(clk), .reset(reset),
        .oscillatorInput(osc), .clockSourceSelectPin(src),
        .contrastOffsetStrapLow(sLo), .contrastOffsetStrapHigh(sHi),
        .byteValid(bv), .byteData(bd), .byteIsCommand(bc), .byteIsIcon(bi),
        .standby(sb), .busy(bz), .frameTick(ft), .internalClockTick(it),
        .dividerSelect(ds), .contrastCount(cc), .contrastLevel(cl),
        .outputsAtSupply(oas), .iconValid(iv), .iconData(id));
    // clock and oscillator
    initial forever #12.5 clk = ~clk;
    initial forever begin
        repeat (2) @(posedge clk);
        #1 osc = ~osc;
    end
    task chk(input [7:0] seen, input [7:0] exp, input string nm);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // bounded wait for a tick or for busy low
    task waitFor(input sel, output integer c);
        begin
            c = 0;
            do begin
                @(posedge clk) #1;
                c = c + 1;
                if (c > 3000) begin
                    num_errors = num_errors + 1;
                    finish_test;
                end
            end while (sel ? it !== 1'b1 : bz !== 1'b0);
        end
    endtask
    // send a byte, step the model, compare
    task send(input c, input i, input [7:0] d);
        begin
            host_u.put(c, i, d);
            if (!eS || d[0]) begin
                eS = 0;
                if (c && (d & 8'hf0) == 8'ha0) eD = d[1:0];
                if (c && (d & 8'hee) == 8'h82) eC = (eC + (d[0] ? 1 : 7)) % 8;
                if (c && (d & 8'hef) == 8'h84) eS = 1;
                if (i && !c) chk(id, {3'h0, d[4:0]}, "icon");
            end
            if (!eS) waitFor(0, n);
            #1 @(posedge clk) #1;
            chk(sb, eS[7:0], "standby");
            chk(oas, eS[7:0], "supply");
            chk(ds, eD[7:0], "divider");
            chk(cc, eC[7:0], "contrast");
        end
    endtask
    initial begin
        n = $urandom(71);
        sLo = $urandom;
        sHi = $urandom;
        repeat (6) @(posedge clk);
        #1 reset = 1'b0;
        eS = 1;
        eD = 3;
        eC = 0;
        send(1, 0, 8'ha2);
        send(1, 0, 8'ha1);
        for (k = 0; k < 4; k = k + 1) begin
            send(1, 0, 8'ha0 | k[1:0]);
            waitFor(1, n);
            waitFor(1, n);
            chk(n[7:0], 8'h08 << k, "period");
        end
        // direct source when the select pin is high
        src = 1'b1;
        repeat (3) waitFor(1, n);
        chk(n[7:0], 8'h04, "direct");
        src = 1'b0;
        for (k = 0; k < 12; k = k + 1)
            send(1, 0, k < 9 ? 8'h93 : 8'h82 | 8'($urandom % 2));
        chk({4'h0, cl}, eC[7:0] + {6'h0, sHi, sLo}, "level");
        send(0, 1, 8'($urandom));
        send(1, 0, 8'h94);
        send(0, 1, 8'h1e);
        send(0, 0, 8'h05);
        reset = 1'b1;
        repeat (2) @(posedge clk);
        #1 reset = 1'b0;
        @(posedge clk) #1;
        chk(cc, 8'h00, "reset contrast");
        chk(sb, 8'h01, "reset standby");
        finish_test;
    end
endmodule
